/* src/sigmod_pkg.sv */
// ==========================================================
// Register map, field layout and reset values
// ==========================================================
package sigmod_pkg;
    // Register byte offsets
    localparam logic [7:0] SIGMOD_CON_OFS = 8'h00;
    localparam logic [7:0] SIGMOD_SRC_OFS = 8'h04;
    localparam logic [7:0] SIGMOD_CARRIER_HIGH_SIGNAL_OFS = 8'h08;
    localparam logic [7:0] SIGMOD_CARRIER_LOW_SIGNAL_OFS = 8'h0C;

    // Control register fields
    localparam int SIGMOD_CON_EN = 7;
    localparam int SIGMOD_CON_OE = 6;
    localparam int SIGMOD_CON_SLR = 5;
    localparam int SIGMOD_CON_POL = 4;
    localparam int SIGMOD_CON_OUT = 3;
    localparam int SIGMOD_CON_BIT = 0;

    // Source and carrier register fields
    localparam int SIGMOD_SEL_LSB = 0;
    localparam int SIGMOD_ODIS = 7;
    localparam int SIGMOD_CPOL = 6;
    localparam int SIGMOD_CSYNC = 5;

    // Writable bit masks
    localparam logic [7:0] SIGMOD_CON_WMASK = 8'hF1;
    localparam logic [7:0] SIGMOD_SRC_WMASK = 8'h8F;
    localparam logic [7:0] SIGMOD_CAR_WMASK = 8'hEF;

    // Values after reset
    localparam logic [7:0] SIGMOD_CON_RST = 8'h20;
    localparam logic [7:0] SIGMOD_SRC_RST = 8'h00;
    localparam logic [7:0] SIGMOD_CAR_RST = 8'h00;

    // Modulator source codes
    localparam logic [3:0] SIGMOD_MS_SWBIT = 4'h0;
    localparam logic [3:0] SIGMOD_MS_PIN = 4'h1;
    localparam logic [3:0] SIGMOD_MS_PWM1 = 4'h2;
    localparam logic [3:0] SIGMOD_MS_CMP1 = 4'h6;
    localparam logic [3:0] SIGMOD_MS_CMP2 = 4'h7;
    localparam logic [3:0] SIGMOD_MS_SSP1 = 4'h8;
    localparam logic [3:0] SIGMOD_MS_SSP2 = 4'h9;
    localparam logic [3:0] SIGMOD_MS_UART = 4'hA;

    // Carrier source codes
    localparam logic [3:0] SIGMOD_CS_GND = 4'h0;
    localparam logic [3:0] SIGMOD_CS_PIN_A = 4'h1;
    localparam logic [3:0] SIGMOD_CS_PIN_B = 4'h2;
    localparam logic [3:0] SIGMOD_CS_REFCLK = 4'h3;
    localparam logic [3:0] SIGMOD_CS_PWM1 = 4'h4;

    // Sampled copies of the mixing path
    localparam int SIGMOD_SYNC_W = 4;

    // AHB transfer type
    localparam logic [1:0] SIGMOD_HTRANS_NONSEQ = 2'b10;
endpackage

/* src/sigmod_sync.sv */
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for asynchronous levels
// ==========================================================
module sigmod_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage is read only by the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

/* src/sigmod_top.sv */
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// ==========================================================
// Signal modulator with AHB-Lite register slave
// ==========================================================
// Operation
// - Output is the carrier picked by the modulator, to pin
// - Modulator high mixes the high carrier
// - Modulator low mixes the low carrier
// - Mixing starts only after enable set
// - Disabled: both carriers forced to ground
// - Disabled: modulator taken from software bit
// - Disable keeps stored source selections
// - Re-enable reapplies stored source selections
// - Pin disable keeps internal mixing running
// - Pin held low while pin disabled
// - Pin disable does not stop module
// - Eleven modulator sources offered
// - Four-bit field picks modulator source
// - Eight carrier sources offered
// - Four-bit field picks high carrier
// - Separate four-bit field picks low carrier
// - Source codes fixed, modulator above ten and carrier above seven connect nothing
// - Polarity bit inverts the modulated output
// - Reset disables module, restores defaults
// - Synchronised carrier falls low before switching
module sigmod_top
    import sigmod_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] pwm_out,
    input wire logic ssp1_sdo,
    input wire logic ssp2_sdo,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    input wire logic uart_tx,
    input wire logic ref_clk_out,
    input wire logic external_modulator_pin,
    input wire logic external_carrier_pin_a,
    input wire logic external_carrier_pin_b,
    output logic modulated_output_pin,
    output logic slew_limit_en,
    output logic mod_src_pin_dis,
    output logic carrier_high_signal_src_pin_dis,
    output logic carrier_low_signal_src_pin_dis
);
    // ======================================================
    // Decode functions
    // ======================================================
    // Modulator source multiplexer
    // reserved codes idle
    function automatic logic pick_mod(input logic [3:0] sel, input logic sw,
                                      input logic [10:0] src);
        logic r;
        r = 1'b0;
        if (sel == SIGMOD_MS_SWBIT) begin
            r = sw;
        end else if (sel <= SIGMOD_MS_UART) begin
            r = src[sel];
        end
        return r;
    endfunction

    // Carrier source multiplexer, unused codes give ground
    function automatic logic pick_car(input logic [3:0] sel, input logic [7:0] src);
        logic r;
        r = 1'b0;
        if (sel <= 4'h7) begin
            r = src[sel[2:0]];
        end
        return r;
    endfunction

    // ======================================================
    // Registers
    // ======================================================
    logic [7:0] con_q;
    logic [7:0] src_q;
    logic [7:0] carrier_high_signal_q;
    logic [7:0] carrier_low_signal_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic addr_ok;
    logic [7:0] addr_lo;
    logic out_s;
    logic mod_s;
    logic carrier_high_signal_s;
    logic carrier_low_signal_s;

    assign addr_lo = haddr[7:0];
    assign addr_ok = hsel && hready && htrans == SIGMOD_HTRANS_NONSEQ;

    // Zero-wait slave, stalls only while frozen
    assign hreadyout = ce;
    assign hresp = 1'b0;

    // Address phase capture for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (ce) begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= addr_lo;
        end
    end

    // reset defaults
    // Control register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            con_q <= SIGMOD_CON_RST;
        end else if (ce && wr_pend_q && wr_addr_q == SIGMOD_CON_OFS) begin
            con_q <= hwdata[7:0] & SIGMOD_CON_WMASK;
        end
    end

    // selections kept
    // Source register writes, only software changes them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= SIGMOD_SRC_RST;
        end else if (ce && wr_pend_q && wr_addr_q == SIGMOD_SRC_OFS) begin
            src_q <= hwdata[7:0] & SIGMOD_SRC_WMASK;
        end
    end

    // Carrier register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carrier_high_signal_q <= SIGMOD_CAR_RST;
            carrier_low_signal_q <= SIGMOD_CAR_RST;
        end else if (ce && wr_pend_q) begin
            if (wr_addr_q == SIGMOD_CARRIER_HIGH_SIGNAL_OFS) begin
                carrier_high_signal_q <= hwdata[7:0] & SIGMOD_CAR_WMASK;
            end
            if (wr_addr_q == SIGMOD_CARRIER_LOW_SIGNAL_OFS) begin
                carrier_low_signal_q <= hwdata[7:0] & SIGMOD_CAR_WMASK;
            end
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && addr_ok && !hwrite) begin
            case (addr_lo)
                SIGMOD_CON_OFS: begin
                    hrdata <= {24'h000000, con_q[7:4], out_s, 3'b000} |
                              {31'h0000_0000, con_q[SIGMOD_CON_BIT]};
                end
                SIGMOD_SRC_OFS: begin
                    hrdata <= {24'h000000, src_q};
                end
                SIGMOD_CARRIER_HIGH_SIGNAL_OFS: begin
                    hrdata <= {24'h000000, carrier_high_signal_q};
                end
                SIGMOD_CARRIER_LOW_SIGNAL_OFS: begin
                    hrdata <= {24'h000000, carrier_low_signal_q};
                end
                default: begin
                    hrdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ======================================================
    // Mixing path
    // ======================================================
    logic en;
    logic oe;
    logic opol;
    logic [10:0] mod_src;
    logic [7:0] car_src;
    logic mod_sig;
    logic carrier_high_signal_sig;
    logic carrier_low_signal_sig;
    logic sel_high_q;
    logic sel_eff;
    logic mix;

    // Control and pin-disable fields
    // enable gates mixing
    assign en = con_q[SIGMOD_CON_EN];
    assign oe = con_q[SIGMOD_CON_OE];
    assign opol = con_q[SIGMOD_CON_POL];
    assign slew_limit_en = con_q[SIGMOD_CON_SLR];
    assign mod_src_pin_dis = src_q[SIGMOD_ODIS];
    assign carrier_high_signal_src_pin_dis = carrier_high_signal_q[SIGMOD_ODIS];
    assign carrier_low_signal_src_pin_dis = carrier_low_signal_q[SIGMOD_ODIS];

    assign mod_src = {uart_tx, ssp2_sdo, ssp1_sdo, cmp2_out, cmp1_out,
                      pwm_out, external_modulator_pin, 1'b0};
    assign car_src = {pwm_out, ref_clk_out, external_carrier_pin_b,
                      external_carrier_pin_a, 1'b0};

    assign mod_sig = en ? pick_mod(src_q[3:0], con_q[SIGMOD_CON_BIT], mod_src)
                        : con_q[SIGMOD_CON_BIT];

    assign carrier_high_signal_sig = en && (pick_car(carrier_high_signal_q[3:0], car_src) ^ carrier_high_signal_q[SIGMOD_CPOL]);
    assign carrier_low_signal_sig = en && (pick_car(carrier_low_signal_q[3:0], car_src) ^ carrier_low_signal_q[SIGMOD_CPOL]);

    // use held selection while outgoing carrier is synchronised
    assign sel_eff = (sel_high_q ? carrier_high_signal_q[SIGMOD_CSYNC] : carrier_low_signal_q[SIGMOD_CSYNC]) ?
                     sel_high_q : mod_sig;

    assign mix = sel_eff ? carrier_high_signal_sig : carrier_low_signal_sig;

    assign modulated_output_pin = oe ? (mix ^ opol) : 1'b0;

    // Sampled copies for sync decisions and status readback
    sigmod_sync #(
        .W(SIGMOD_SYNC_W)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .async_in({modulated_output_pin, mod_sig, carrier_high_signal_sig, carrier_low_signal_sig}),
        .sync_out({out_s, mod_s, carrier_high_signal_s, carrier_low_signal_s})
    );

    // switch once the outgoing carrier is low, or at once if it is not synchronised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_high_q <= 1'b0;
        end else if (ce && mod_s != sel_high_q) begin
            if (sel_high_q ? !(carrier_high_signal_q[SIGMOD_CSYNC] && carrier_high_signal_s)
                           : !(carrier_low_signal_q[SIGMOD_CSYNC] && carrier_low_signal_s)) begin
                sel_high_q <= mod_s;
            end
        end
    end

    // ======================================================
    // Assertions
    // ======================================================
    logic con_wr;
    logic sel_wr;
    assign con_wr = ce && wr_pend_q && wr_addr_q == SIGMOD_CON_OFS;
    assign sel_wr = ce && wr_pend_q && wr_addr_q != SIGMOD_CON_OFS;

    a_and_mix: assert property (@(posedge hclk) disable iff (!hresetn)
        oe && !opol |-> modulated_output_pin == (sel_eff ? carrier_high_signal_sig : carrier_low_signal_sig))
        else $error("output is not the selected mix");

    a_high_carrier: assert property (@(posedge hclk) disable iff (!hresetn)
        en && oe && !opol && mod_sig && !carrier_high_signal_q[SIGMOD_CSYNC] && !carrier_low_signal_q[SIGMOD_CSYNC]
        |-> modulated_output_pin == carrier_high_signal_sig)
        else $error("high carrier not mixed");

    a_low_carrier: assert property (@(posedge hclk) disable iff (!hresetn)
        en && oe && !opol && !mod_sig && !carrier_high_signal_q[SIGMOD_CSYNC] && !carrier_low_signal_q[SIGMOD_CSYNC]
        |-> modulated_output_pin == carrier_low_signal_sig)
        else $error("low carrier not mixed");

    a_off_ground: assert property (@(posedge hclk) disable iff (!hresetn)
        !en |-> !carrier_high_signal_sig && !carrier_low_signal_sig && (modulated_output_pin == (oe && opol)))
        else $error("carriers not grounded while disabled");

    a_off_swbit: assert property (@(posedge hclk) disable iff (!hresetn)
        !en |-> mod_sig == con_q[SIGMOD_CON_BIT])
        else $error("modulator not from software bit");

    a_sel_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        !sel_wr |=> $stable(src_q) && $stable(carrier_high_signal_q) && $stable(carrier_low_signal_q))
        else $error("selection changed without a write");

    a_pin_low: assert property (@(posedge hclk) disable iff (!hresetn)
        !oe |-> !modulated_output_pin)
        else $error("pin not low while disabled");

    a_src_pin: assert property (@(posedge hclk) disable iff (!hresetn)
        en && src_q[3:0] == SIGMOD_MS_PIN |-> mod_sig == external_modulator_pin)
        else $error("pin source not routed");

    a_reserved_src: assert property (@(posedge hclk) disable iff (!hresetn)
        en && src_q[3:0] > SIGMOD_MS_UART |-> !mod_sig)
        else $error("reserved source not idle");

    a_invert: assert property (@(posedge hclk) disable iff (!hresetn)
        oe && opol |-> modulated_output_pin == !mix)
        else $error("polarity not applied");

    a_sync_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        ce && sel_high_q && carrier_high_signal_q[SIGMOD_CSYNC] && carrier_high_signal_s && !mod_s |=> sel_high_q)
        else $error("synchronised carrier cut short");

    a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
        con_wr && hwdata[SIGMOD_CON_EN] |=> en ##1 (en || $past(con_wr)))
        else $error("enable write not taken");

    a_reset_state: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> con_q == SIGMOD_CON_RST && src_q == SIGMOD_SRC_RST
        && carrier_high_signal_q == SIGMOD_CAR_RST && carrier_low_signal_q == SIGMOD_CAR_RST && !sel_high_q)
        else $error("registers not at defaults after reset");

    a_reapply_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(en) && src_q[3:0] == SIGMOD_MS_PIN |-> mod_sig == external_modulator_pin)
        else $error("stored modulator source not reapplied");

    a_oe_keeps_en: assert property (@(posedge hclk) disable iff (!hresetn)
        !oe && !con_wr |=> en == $past(en))
        else $error("pin disable changed the enable");

    a_carrier_high_signal_route: assert property (@(posedge hclk) disable iff (!hresetn)
        en && carrier_high_signal_q[3:0] == SIGMOD_CS_PIN_A
        |-> carrier_high_signal_sig == (external_carrier_pin_a ^ carrier_high_signal_q[SIGMOD_CPOL]))
        else $error("high carrier pin not routed");

    c_fsk_run: cover property (@(posedge hclk) disable iff (!hresetn)
        en && oe && mod_sig ##[1:20] en && oe && !mod_sig);
    c_sync_hold: cover property (@(posedge hclk) disable iff (!hresetn)
        sel_high_q && carrier_high_signal_q[SIGMOD_CSYNC] && carrier_high_signal_s && !mod_s);
    c_reg_read: cover property (@(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && addr_lo == SIGMOD_CON_OFS);
    c_pin_off_mix: cover property (@(posedge hclk) disable iff (!hresetn)
        en && !oe && mix);
endmodule

/* sim/sigmod_src_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Peripheral and pin levels feeding the mixer
// ==========================================================
module sigmod_src_model (
    input wire logic hclk,
    input wire logic slow,
    input wire logic [11:0] lvl,
    output logic [3:0] pwm_out,
    output logic ssp1_sdo,
    output logic ssp2_sdo,
    output logic cmp1_out,
    output logic cmp2_out,
    output logic uart_tx,
    output logic ref_clk_out,
    output logic external_modulator_pin,
    output logic external_carrier_pin_a,
    output logic external_carrier_pin_b
);
    logic [1:0] div_q = 2'b00;
    logic [11:0] lvl_q = 12'h000;

    // Free-running divider; bit 0 is a reference clock at half the bus rate
    always_ff @(posedge hclk) begin
        div_q <= div_q + 2'b01;
    end

    // Levels follow each cycle, or only every fourth cycle when slow
    always_ff @(posedge hclk) begin
        if (!slow || div_q == 2'b11) begin
            lvl_q <= lvl;
        end
    end

    // Outputs taken apart from the held level word
    assign ref_clk_out = div_q[0];
    assign {external_carrier_pin_b, external_carrier_pin_a, external_modulator_pin, uart_tx,
            cmp2_out, cmp1_out, ssp2_sdo, ssp1_sdo, pwm_out} = lvl_q;
endmodule

/* sim/sigmod_tb_top.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the signal modulator
// ==========================================================
module sigmod_tb_top;
    import sigmod_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic slow = 1'b0;
    logic [11:0] lvl = 12'h000;
    logic hreadyout, hresp, pin, slew_limit_en, msd, chd, cld;
    logic [31:0] hrdata;
    logic [3:0] pwm;
    logic s1, s2, c1, c2, tx, rclk, em, ea, eb;
    logic [12:0] sv;
    logic [7:0] reg_v [4];
    logic [31:0] rng = 32'd67372;
    logic [31:0] q;
    int n_errors = 0;
    int checks_done = 0;

    // ==========================================================
    // Clock, design and source model
    // ==========================================================
    always #5 hclk = ~hclk;
    assign sv = {eb, ea, em, rclk, tx, c2, c1, s2, s1, pwm};

    sigmod_top uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pwm_out(pwm), .ssp1_sdo(s1), .ssp2_sdo(s2), .cmp1_out(c1), .cmp2_out(c2),
        .uart_tx(tx), .ref_clk_out(rclk), .external_modulator_pin(em),
        .external_carrier_pin_a(ea), .external_carrier_pin_b(eb),
        .modulated_output_pin(pin), .slew_limit_en(slew_limit_en),
        .mod_src_pin_dis(msd), .carrier_high_signal_src_pin_dis(chd), .carrier_low_signal_src_pin_dis(cld));

    sigmod_src_model model (.hclk(hclk), .slow(slow), .lvl(lvl), .pwm_out(pwm),
        .ssp1_sdo(s1), .ssp2_sdo(s2), .cmp1_out(c1), .cmp2_out(c2), .uart_tx(tx),
        .ref_clk_out(rclk), .external_modulator_pin(em), .external_carrier_pin_a(ea),
        .external_carrier_pin_b(eb));

    // ==========================================================
    // Expectation functions
    // ==========================================================
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    // Carrier pick with its own inversion
    function automatic logic car(input logic [7:0] c, input logic [12:0] s);
        logic v;
        case (c[3:0])
            4'h1: v = s[11];
            4'h2: v = s[12];
            4'h3: v = s[9];
            4'h4, 4'h5, 4'h6, 4'h7: v = s[c[1:0]];
            default: v = 1'b0;
        endcase
        return v ^ c[6];
    endfunction

    // Pin level from the register copies and the source levels
    function automatic logic exp_pin(input logic [12:0] s);
        logic m, h, l;
        logic [3:0] k;
        k = reg_v[1][3:0] - 4'h2;
        case (reg_v[1][3:0])
            4'h0: m = reg_v[0][0];
            4'h1: m = s[10];
            4'h2, 4'h3, 4'h4, 4'h5: m = s[k];
            4'h6: m = s[6];
            4'h7: m = s[7];
            4'h8: m = s[4];
            4'h9: m = s[5];
            4'hA: m = s[8];
            default: m = 1'b0;
        endcase
        h = car(reg_v[2], s);
        l = car(reg_v[3], s);
        if (!reg_v[0][7]) begin
            m = reg_v[0][0];
            h = 1'b0;
            l = 1'b0;
        end
        return ((m ? h : l) ^ reg_v[0][4]) & reg_v[0][6];
    endfunction

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // Wait for hready under a bounded count
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1);
    endtask

    // One single AHB-Lite word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= SIGMOD_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input int i, input logic [7:0] d);
        bus(1'b1, 8'(i * 4), d);
        reg_v[i] = d & (i == 0 ? SIGMOD_CON_WMASK : i == 1 ? SIGMOD_SRC_WMASK : SIGMOD_CAR_WMASK);
    endtask

    // Read back every register, status bit masked
    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'(i * 4), 8'h00);
            check(q & ~(i == 0 ? 32'h8 : 32'h0), {24'h0, reg_v[i]});
        end
        check({msd, chd, cld}, {reg_v[1][7], reg_v[2][7], reg_v[3][7]});
    endtask

    // Pin compared each cycle while source levels move
    task automatic pin_chk(input int n);
        repeat (n) begin
            @(negedge hclk);
            check(pin, exp_pin(sv));
            @(posedge hclk);
            lvl <= 12'(xs());
        end
    endtask

    task automatic rst_dut();
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        reg_v = '{SIGMOD_CON_RST, SIGMOD_SRC_RST, SIGMOD_CAR_RST, SIGMOD_CAR_RST};
        @(posedge hclk);
    endtask

    // ==========================================================
    // Watchdog and main sequence
    // ==========================================================
    initial begin
        #500000;
        n_errors++;
        stop_test();
    end

    initial begin
        rst_dut();
        rd_all();
        check(slew_limit_en, 1'b1);
        check(hresp, 1'b0);
        pin_chk(3);
        bus(1'b0, 8'h10, 8'h00);
        check(q, 32'h0);
        for (int k = 0; k < 16; k++) begin
            wr(0, 8'hC0 | 8'(xs() & 32'h11));
            wr(1, 8'(k));
            wr(2, (8'(xs()) & 8'hC0) | 8'(k));
            wr(3, (8'(xs()) & 8'hC0) | 8'(15 - k));
            pin_chk(6);
        end
        // random configurations, prompt and slow sources
        for (int k = 0; k < 150; k++) begin
            slow <= (k % 8) > 5;
            wr(0, 8'(xs()));
            wr(1, 8'(xs()));
            wr(2, 8'(xs()) & 8'hDF);
            wr(3, 8'(xs()) & 8'hDF);
            pin_chk(4);
            if (k % 10 == 0) rd_all();
        end
        // disable keeps selections, enable reapplies them
        wr(0, reg_v[0] & 8'h7F);
        rd_all();
        pin_chk(4);
        wr(0, reg_v[0] | 8'hC0);
        pin_chk(4);
        // pin disable, status bit low, inverted ground high, and back
        wr(0, 8'h80);
        pin_chk(4);
        bus(1'b0, SIGMOD_CON_OFS, 8'h00);
        check(q, 32'h0000_0080);
        wr(0, 8'h50);
        pin_chk(3);
        bus(1'b0, SIGMOD_CON_OFS, 8'h00);
        check(q, 32'h0000_0058);
        wr(0, 8'hC0);
        pin_chk(4);
        rst_dut();
        rd_all();
        pin_chk(2);
        stop_test();
    end
endmodule
